// file: inc/tla_params.svh
// Constants for the two-level interrupt arbiter
`ifndef TLA_PARAMS_SVH
`define TLA_PARAMS_SVH

`define TLA_NSRC          22
`define TLA_IDX_W         5
`define TLA_VEC_W         16
`define TLA_VEC_BASE      16'h0003
`define TLA_VEC_STEP      16'h0008
`define TLA_ORD_CONV      15
`define TLA_ORD_SOFT0     16
`define TLA_NSOFT         4
`define TLA_ORD_UNUSED    20
`define TLA_ORD_OSC       21
`define TLA_NLEGACY       15
`define TLA_CONV_PEND_BIT 5
`define TLA_SOFT0_BIT     4
`define TLA_OSC_PEND_BIT  7
`define TLA_EXT_EN_OFS    14
`define TLA_DETECT_CYC    1
`define TLA_CALL_CYC      4
`define TLA_CALL_CNT_W    3
`define TLA_PRIO_RESET    22'h000000

`endif

// file: inc/tla_pkg.sv
// Types shared by the interrupt arbiter modules
`include "tla_params.svh"

package tla_pkg;

    typedef enum logic [1:0] {
        TLA_ST_IDLE  = 2'b00,
        TLA_ST_CALL  = 2'b01,
        TLA_ST_ENTRY = 2'b10
    } tla_state_t;

    typedef struct packed {
        logic insn_end;
        logic insn_is_return_from_irq_insn;
    } tla_cpu_t;

    typedef struct packed {
        logic                  busy;
        logic                  enter;
        logic                  level_high;
        logic [`TLA_VEC_W-1:0] vector;
    } tla_call_t;

endpackage : tla_pkg

// file: core/tla_prio_enc.sv
// Fixed-order priority encoder, lowest index wins
`timescale 1ns/10ps
`default_nettype none

module tla_prio_enc #(
    parameter int N     = 22,
    parameter int IDX_W = 5
) (
    input  wire logic [N-1:0]     i_req,
    output logic                  o_valid,
    output logic [IDX_W-1:0]      o_index
);
    import tla_pkg::*;

    logic [N:0]   below;
    logic [N-1:0] onehot;

    assign below[0] = 1'b0;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_chain
            assign onehot[g]  = i_req[g] & ~below[g];
            assign below[g+1] = below[g] | i_req[g];
        end
    endgenerate

    assign o_valid = below[N];

    always_comb begin
        o_index = '0;
        for (int k = 0; k < N; k++) begin
            if (onehot[k]) begin
                o_index = o_index | IDX_W'(k);
            end
        end
    end

endmodule : tla_prio_enc

`default_nettype wire

// file: core/tla_call_timer.sv
// Cycle counter for the long call into a handler
`timescale 1ns/10ps
`default_nettype none
`include "tla_params.svh"

module tla_call_timer #(
    parameter int                CNT_W  = 3,
    parameter logic [CNT_W-1:0]  CYCLES = CNT_W'(`TLA_CALL_CYC)
) (
    input  wire logic            i_clk,
    input  wire logic            i_rst_b,
    input  wire logic            i_start,
    input  wire logic            i_hold,
    output logic                 o_busy,
    output logic                 o_done
);
    import tla_pkg::*;

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    // Counter freezes while the core is stalled
    always_comb begin
        cnt_d = cnt_q;
        if (i_start) begin
            cnt_d = CYCLES;
        end else if (cnt_q != '0 && !i_hold) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_busy = (cnt_q != '0);
    assign o_done = (cnt_q == CNT_W'(1)) && !i_hold;

endmodule : tla_call_timer

`default_nettype wire

// file: core/tla_arbiter.sv
// Two-level interrupt arbiter and long-call dispatcher
`timescale 1ns/10ps
`default_nettype none
`include "tla_params.svh"

// Function
// (RULE1) Each source selectable low or high level
// (RULE2) High preempts low; high never preempted
// (RULE3) One priority bit per source, resets low
// (RULE4) Higher level wins among simultaneous requests
// (RULE5) Same level: lower order number wins
// (RULE6) Sample and decode requests every clock
// (RULE7) Detect one clock, long call four clocks
// (RULE8) One instruction after return before call
// (RULE9) Worst case response eighteen clocks
// (RULE10) Stall core, defer service during flash
// (RULE11) Equal/higher active handler blocks new service
// (RULE12) Conversion done vectors 0x007B, order 15
// (RULE13) Four soft sources, 0x0083-0x009B, orders 16-19
// (RULE14) Oscillator ready vectors 0x00AB, order 21
// (RULE15) Request needs pending, enable, global enable
// (RULE16) Unused slot never requests
module tla_arbiter #(
    parameter int NSRC   = `TLA_NSRC,
    parameter int IDX_W  = `TLA_IDX_W,
    parameter int NLEG   = `TLA_NLEGACY
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst_b,
    input  wire logic                    i_global_enable,
    input  wire logic [NLEG-1:0]         i_legacy_pending,
    input  wire logic [NLEG-1:0]         i_legacy_enable,
    input  wire logic [7:0]              i_converter_control_reg,
    input  wire logic [7:0]              i_soft_irq_register,
    input  wire logic [7:0]              i_ext_osc_control_reg,
    input  wire logic [7:0]              i_extended_enable_reg2,
    input  wire logic                    i_prio_wr_en,
    input  wire logic [NSRC-1:0]         i_prio_wr_data,
    input  wire tla_pkg::tla_cpu_t       i_cpu,
    input  wire logic                    i_flash_busy,
    output tla_pkg::tla_call_t           o_call,
    output logic [IDX_W-1:0]             o_call_index,
    output logic                         o_cpu_stall,
    output logic [NSRC-1:0]              o_priority_select,
    output logic                         o_high_active,
    output logic                         o_low_active,
    output logic                         o_return_from_irq_insn_hold,
    output logic                         o_request_seen
);
    import tla_pkg::*;

    // Named pending and enable bits of the extended sources
    logic             conversion_done_pending;
    logic             conversion_done_enable;
    logic [`TLA_NSOFT-1:0] soft_irq_pending;
    logic [`TLA_NSOFT-1:0] soft_irq_enable;
    logic             osc_valid_pending;
    logic             osc_valid_enable;

    assign conversion_done_pending = i_converter_control_reg[`TLA_CONV_PEND_BIT];
    assign soft_irq_pending        = i_soft_irq_register[`TLA_SOFT0_BIT +: `TLA_NSOFT];
    assign osc_valid_pending       = i_ext_osc_control_reg[`TLA_OSC_PEND_BIT];
    assign conversion_done_enable  =
        i_extended_enable_reg2[`TLA_ORD_CONV - `TLA_EXT_EN_OFS];
    assign soft_irq_enable         =
        i_extended_enable_reg2[`TLA_ORD_SOFT0 - `TLA_EXT_EN_OFS +: `TLA_NSOFT];
    assign osc_valid_enable        =
        i_extended_enable_reg2[`TLA_ORD_OSC - `TLA_EXT_EN_OFS];

    // Source vectors in arbitration order
    logic [NSRC-1:0] src_pending;
    logic [NSRC-1:0] src_enable;
    logic [NSRC-1:0] raw_req;

    always_comb begin
        src_pending                                = '0;
        src_enable                                 = '0;
        src_pending[NLEG-1:0]                      = i_legacy_pending;
        src_enable[NLEG-1:0]                       = i_legacy_enable;
        src_pending[`TLA_ORD_CONV]                 = conversion_done_pending; // see (RULE12)
        src_enable[`TLA_ORD_CONV]                  = conversion_done_enable;
        src_pending[`TLA_ORD_SOFT0 +: `TLA_NSOFT]  = soft_irq_pending;        // see (RULE13)
        src_enable[`TLA_ORD_SOFT0 +: `TLA_NSOFT]   = soft_irq_enable;
        src_pending[`TLA_ORD_OSC]                  = osc_valid_pending;       // see (RULE14)
        src_enable[`TLA_ORD_OSC]                   = osc_valid_enable;
        src_pending[`TLA_ORD_UNUSED]               = 1'b0;                    // see (RULE16)
        src_enable[`TLA_ORD_UNUSED]                = 1'b0;                    // see (RULE16)
    end

    // Qualified request per source
    always_comb begin
        raw_req = src_pending & src_enable & {NSRC{i_global_enable}};         // see (RULE15)
    end

    // Detection stage: sampled on every clock
    logic [NSRC-1:0] req_q;
    logic [NSRC-1:0] req_d;

    always_comb begin
        req_d = raw_req;                                                      // see (RULE6)
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // Priority-select bits, one per source
    logic [NSRC-1:0] prio_q;
    logic [NSRC-1:0] prio_d;

    always_comb begin
        prio_d = prio_q;
        if (i_prio_wr_en) begin
            prio_d = i_prio_wr_data;                                          // see (RULE1)
        end
        prio_d[`TLA_ORD_UNUSED] = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prio_q <= `TLA_PRIO_RESET;                                        // see (RULE3)
        end else begin
            prio_q <= prio_d;
        end
    end

    // Split requests by level and decode each
    logic [NSRC-1:0] hi_req;
    logic [NSRC-1:0] lo_req;
    logic            hi_valid;
    logic            lo_valid;
    logic [IDX_W-1:0] hi_index;
    logic [IDX_W-1:0] lo_index;

    assign hi_req = req_q & prio_q;
    assign lo_req = req_q & ~prio_q;

    tla_prio_enc #(
        .N     (NSRC),
        .IDX_W (IDX_W)
    ) u_enc_hi (
        .i_req   (hi_req),
        .o_valid (hi_valid),
        .o_index (hi_index)
    );

    tla_prio_enc #(
        .N     (NSRC),
        .IDX_W (IDX_W)
    ) u_enc_lo (
        .i_req   (lo_req),
        .o_valid (lo_valid),
        .o_index (lo_index)
    );

    // In-service levels and the post-return hold
    logic hi_act_q;
    logic hi_act_d;
    logic lo_act_q;
    logic lo_act_d;
    logic hold_q;
    logic hold_d;

    // Call sequencing state
    tla_state_t        state_q;
    tla_state_t        state_d;
    logic [`TLA_VEC_W-1:0] vec_q;
    logic [`TLA_VEC_W-1:0] vec_d;
    logic [IDX_W-1:0]  idx_q;
    logic [IDX_W-1:0]  idx_d;
    logic              lvl_q;
    logic              lvl_d;

    logic              boundary;
    logic              pick_hi;
    logic              pick_lo;
    logic              take;
    logic [IDX_W-1:0]  win_index;
    logic              call_done;

    // Calls only at the end of an ordinary instruction
    assign boundary = i_cpu.insn_end && !i_cpu.insn_is_return_from_irq_insn                  // see (RULE8)
                      && !i_flash_busy;                                       // see (RULE10)

    always_comb begin
        pick_hi = hi_valid && !hi_act_q;                                      // see (RULE2)
        pick_lo = lo_valid && !hi_act_q && !lo_act_q;                         // see (RULE11)
    end

    assign take      = (state_q == TLA_ST_IDLE) && boundary            // see (RULE9)
                       && (pick_hi || pick_lo);
    assign win_index = pick_hi ? hi_index : lo_index;                         // see (RULE4)

    // Fixed vector from arbitration order
    function automatic logic [`TLA_VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
        logic [`TLA_VEC_W-1:0] ofs;
        ofs    = `TLA_VEC_STEP * `TLA_VEC_W'(idx);                            // see (RULE5)
        vec_of = `TLA_VEC_BASE + ofs;                                         // see (RULE12)
    endfunction : vec_of

    tla_call_timer #(
        .CNT_W  (`TLA_CALL_CNT_W),
        .CYCLES (`TLA_CALL_CNT_W'(`TLA_CALL_CYC))
    ) u_call_timer (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_start (take),                                                      // see (RULE7)
        .i_hold  (i_flash_busy),
        .o_busy  (),
        .o_done  (call_done)
    );

    // Call sequencer
    always_comb begin
        state_d = state_q;
        vec_d   = vec_q;
        idx_d   = idx_q;
        lvl_d   = lvl_q;
        case (state_q)
            TLA_ST_IDLE: begin
                if (take) begin
                    state_d = TLA_ST_CALL;
                    vec_d   = vec_of(win_index);
                    idx_d   = win_index;
                    lvl_d   = pick_hi;
                end
            end
            TLA_ST_CALL: begin
                if (call_done) begin
                    state_d = TLA_ST_ENTRY;                                   // see (RULE7)
                end
            end
            TLA_ST_ENTRY: begin
                state_d = TLA_ST_IDLE;
            end
            default: begin
                state_d = TLA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= TLA_ST_IDLE;
            vec_q   <= '0;
            idx_q   <= '0;
            lvl_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            vec_q   <= vec_d;
            idx_q   <= idx_d;
            lvl_q   <= lvl_d;
        end
    end

    // Active-level tracking; return clears the highest active level
    always_comb begin
        hi_act_d = hi_act_q;
        lo_act_d = lo_act_q;
        hold_d   = hold_q;
        if (i_cpu.insn_end) begin
            if (i_cpu.insn_is_return_from_irq_insn) begin
                if (hi_act_q) begin
                    hi_act_d = 1'b0;                                          // see (RULE11)
                end else begin
                    lo_act_d = 1'b0;
                end
                hold_d = 1'b1;                                                // see (RULE8)
            end else begin
                hold_d = 1'b0;
            end
        end
        // Entry after return, so a same-cycle set wins
        if (state_q == TLA_ST_ENTRY) begin
            if (lvl_q) begin
                hi_act_d = 1'b1;                                              // see (RULE2)
            end else begin
                lo_act_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hi_act_q <= 1'b0;
            lo_act_q <= 1'b0;
            hold_q   <= 1'b0;
        end else begin
            hi_act_q <= hi_act_d;
            lo_act_q <= lo_act_d;
            hold_q   <= hold_d;
        end
    end

    // Outputs
    always_comb begin
        o_call.busy       = (state_q == TLA_ST_CALL);
        o_call.enter      = (state_q == TLA_ST_ENTRY);
        o_call.level_high = lvl_q;
        o_call.vector     = vec_q;
    end

    assign o_call_index      = idx_q;
    assign o_cpu_stall       = i_flash_busy;                                  // see (RULE10)
    assign o_priority_select = prio_q;
    assign o_high_active     = hi_act_q;
    assign o_low_active      = lo_act_q;
    assign o_return_from_irq_insn_hold       = hold_q;
    assign o_request_seen    = |req_q;

endmodule : tla_arbiter

`default_nettype wire

// file: dv/tla_arbiter_props.sv
// Port-level checks for the interrupt arbiter
`timescale 1ns/10ps
`default_nettype none

module tla_arbiter_props #(
    parameter int NSRC  = 22,
    parameter int IDX_W = 5,
    parameter int NLEG  = 15
) (
    input wire logic               i_clk,
    input wire logic               i_rst_b,
    input wire logic               i_global_enable,
    input wire logic               i_prio_wr_en,
    input wire logic [NSRC-1:0]    i_prio_wr_data,
    input wire tla_pkg::tla_cpu_t  i_cpu,
    input wire logic               i_flash_busy,
    input wire tla_pkg::tla_call_t o_call,
    input wire logic [IDX_W-1:0]   o_call_index,
    input wire logic               o_cpu_stall,
    input wire logic [NSRC-1:0]    o_priority_select,
    input wire logic               o_high_active,
    input wire logic               o_low_active,
    input wire logic               o_return_from_irq_insn_hold,
    input wire logic               o_request_seen
);
    import tla_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    stall_copy_a: assert property (o_cpu_stall == i_flash_busy)
        else $error("stall differs from flash busy");
    call_len_a: assert property ($rose(o_call.busy) |-> o_call.busy [*4])
        else $error("long call shorter than four cycles");
    entry_follow_a: assert property ($fell(o_call.busy) |-> o_call.enter ##1 !o_call.enter)
        else $error("entry pulse wrong after call");
    take_cond_a: assert property ($rose(o_call.busy) |->
        $past(i_cpu.insn_end) && !$past(i_cpu.insn_is_return_from_irq_insn) && !$past(i_flash_busy))
        else $error("call taken at illegal point");
    vec_map_a: assert property ($rose(o_call.busy) |->
        o_call.vector == 16'h0003 + {o_call_index, 3'h0})
        else $error("vector does not match order");
    slot_unused_a: assert property (o_call.busy |-> 32'(o_call_index) != 32'h14)
        else $error("unused slot serviced");
    prio_load_a: assert property (i_prio_wr_en |=>
        o_priority_select == ($past(i_prio_wr_data) & 22'h2FFFFF))
        else $error("priority bits not loaded");
    high_pre_a: assert property ($rose(o_call.busy) && o_call.level_high |->
        !$past(o_high_active))
        else $error("high handler preempted");
    low_block_a: assert property ($rose(o_call.busy) && !o_call.level_high |->
        !$past(o_high_active) && !$past(o_low_active))
        else $error("low call while handler active");
    gate_off_a: assert property (!$past(i_global_enable) |-> !o_request_seen)
        else $error("request seen with global enable off");
    return_from_irq_insn_hold_a: assert property (i_cpu.insn_end && i_cpu.insn_is_return_from_irq_insn |=> o_return_from_irq_insn_hold)
        else $error("no hold after return");
endmodule : tla_arbiter_props

bind tla_arbiter tla_arbiter_props #(.NSRC(NSRC), .IDX_W(IDX_W), .NLEG(NLEG)) i_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_global_enable(i_global_enable),
    .i_prio_wr_en(i_prio_wr_en), .i_prio_wr_data(i_prio_wr_data), .i_cpu(i_cpu),
    .i_flash_busy(i_flash_busy), .o_call(o_call), .o_call_index(o_call_index),
    .o_cpu_stall(o_cpu_stall), .o_priority_select(o_priority_select),
    .o_high_active(o_high_active), .o_low_active(o_low_active),
    .o_return_from_irq_insn_hold(o_return_from_irq_insn_hold), .o_request_seen(o_request_seen)
);
`default_nettype wire

// file: dv/tla_cpu_model.sv
// Instruction sequencer model facing the arbiter
`timescale 1ns/10ps
`default_nettype none

module tla_cpu_model (
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    input  wire logic [3:0]         i_len,
    input  wire logic               i_return_from_irq_insn_go,
    input  wire tla_pkg::tla_call_t i_call,
    input  wire logic               i_stall,
    output tla_pkg::tla_cpu_t       o_cpu
);
    import tla_pkg::*;
    logic [3:0] cnt_q;
    logic       return_from_irq_insn_q;
    logic       run;
    logic       fire;

    // Core frozen during flash stall and long call
    assign run  = !(i_stall || i_call.busy);
    assign fire = run && (cnt_q + 4'h1 >= i_len);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q  <= 4'h0;
            return_from_irq_insn_q <= 1'h0;
            o_cpu  <= '0;
        end else begin
            o_cpu.insn_end     <= fire;
            o_cpu.insn_is_return_from_irq_insn <= fire && return_from_irq_insn_q;
            if (run) begin
                cnt_q <= fire ? 4'h0 : cnt_q + 4'h1;
            end
            return_from_irq_insn_q <= i_return_from_irq_insn_go || (return_from_irq_insn_q && !fire);
        end
    end
endmodule : tla_cpu_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the interrupt arbiter
`timescale 1ns/10ps
`default_nettype none

module tb;
    import tla_pkg::*;
    logic              i_clk                   = 1'h0;
    logic              i_rst_b                 = 1'h0;
    logic              i_global_enable         = 1'h0;
    logic [14:0]       i_legacy_pending        = '0;
    logic [14:0]       i_legacy_enable         = '0;
    logic [7:0]        i_converter_control_reg = '0;
    logic [7:0]        i_soft_irq_register     = '0;
    logic [7:0]        i_ext_osc_control_reg   = '0;
    logic [7:0]        i_extended_enable_reg2  = '0;
    logic              i_prio_wr_en            = 1'h0;
    logic [21:0]       i_prio_wr_data          = '0;
    logic              i_flash_busy            = 1'h0;
    logic              return_from_irq_insn_go                 = 1'h0;
    logic [3:0]        t_len                   = 4'h1;
    logic [21:0]       pend                    = '0;
    logic [21:0]       en                      = '0;
    tla_cpu_t          i_cpu;
    tla_call_t         o_call;
    logic [4:0]        o_call_index;
    logic [21:0]       o_priority_select;
    logic              o_cpu_stall;
    logic              o_high_active;
    logic              o_low_active;
    logic              o_return_from_irq_insn_hold;
    logic              o_request_seen;
    int                error_cnt = 0;
    int                compares  = 0;
    int                cyc       = 0;

    tla_arbiter i_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_global_enable(i_global_enable),
        .i_legacy_pending(i_legacy_pending), .i_legacy_enable(i_legacy_enable),
        .i_converter_control_reg(i_converter_control_reg),
        .i_soft_irq_register(i_soft_irq_register),
        .i_ext_osc_control_reg(i_ext_osc_control_reg),
        .i_extended_enable_reg2(i_extended_enable_reg2), .i_prio_wr_en(i_prio_wr_en),
        .i_prio_wr_data(i_prio_wr_data), .i_cpu(i_cpu), .i_flash_busy(i_flash_busy),
        .o_call(o_call), .o_call_index(o_call_index), .o_cpu_stall(o_cpu_stall),
        .o_priority_select(o_priority_select), .o_high_active(o_high_active),
        .o_low_active(o_low_active), .o_return_from_irq_insn_hold(o_return_from_irq_insn_hold),
        .o_request_seen(o_request_seen)
    );

    tla_cpu_model i_cpu_mdl (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_len(t_len), .i_return_from_irq_insn_go(return_from_irq_insn_go),
        .i_call(o_call), .i_stall(o_cpu_stall), .o_cpu(i_cpu)
    );

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    // Flag and enable bits spread over their register ports
    always @(posedge i_clk) begin
        i_legacy_pending        <= pend[14:0];
        i_converter_control_reg <= {2'h0, pend[15], 5'h0};
        i_soft_irq_register     <= {pend[19:16], 4'h0};
        i_ext_osc_control_reg   <= {pend[21], 7'h0};
        i_legacy_enable         <= en[14:0];
        i_extended_enable_reg2  <= {en[21:15], 1'h0};
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [21:0] seen, input logic [21:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic serve(input int idx, input logic hi);
        int n;
        n = 0;
        while (o_call.enter !== 1'h1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        chk("enter", 22'(o_call.enter), 22'h1);
        chk("index", 22'(o_call_index), 22'(idx));
        chk("vector", 22'(o_call.vector), 22'(16'h0003 + (16'(idx) << 3)));
        chk("level", 22'(o_call.level_high), 22'(hi));
        pend[idx] = 1'h0;
        @(negedge i_clk);
        chk("active", 22'(hi ? o_high_active : o_low_active), 22'h1);
    endtask : serve

    task automatic do_return_from_irq_insn;
        int n;
        n = 0;
        @(posedge i_clk);
        return_from_irq_insn_go <= 1'h1;
        @(posedge i_clk);
        return_from_irq_insn_go <= 1'h0;
        while (o_return_from_irq_insn_hold !== 1'h1 && n < 50) begin
            @(negedge i_clk);
            n++;
        end
        chk("return_from_irq_insn_hold", 22'(o_return_from_irq_insn_hold), 22'h1);
    endtask : do_return_from_irq_insn

    task automatic quiet(input string nm);
        logic b;
        b = 1'h0;
        repeat (20) begin
            @(negedge i_clk);
            b = b | o_call.busy;
        end
        chk(nm, 22'(b), 22'h0);
    endtask : quiet

    task automatic wr_prio(input logic [21:0] v);
        @(posedge i_clk);
        i_prio_wr_en   <= 1'h1;
        i_prio_wr_data <= v;
        @(posedge i_clk);
        i_prio_wr_en <= 1'h0;
        @(negedge i_clk);
        chk("prio", o_priority_select, v & 22'h2FFFFF);
    endtask : wr_prio

    task automatic t_latency;
        int n;
        chk("prio_reset", o_priority_select, 22'h0);
        pend[4] = 1'h1;
        en[4]   = 1'h1;
        n = 0;
        while (o_call.enter !== 1'h1 && n < 100) begin
            @(negedge i_clk);
            n++;
        end
        chk("fast_resp", 22'(n >= 6 && n <= 7), 22'h1);
        chk("seen_on", 22'(o_request_seen), 22'h1);
        serve(4, 1'h0);
        do_return_from_irq_insn();
    endtask : t_latency

    task automatic t_order;
        wr_prio(22'h3FFFFF);
        wr_prio(22'h000000);
        en   = 22'h3F8000;
        pend = 22'h3F8000;
        for (int k = 15; k < 22; k++) begin
            if (k != 20) begin
                serve(k, 1'h0);
                do_return_from_irq_insn();
            end
        end
        quiet("slot_unused");
    endtask : t_order

    task automatic t_levels;
        wr_prio(22'h000202);
        en[9:0] = 10'h3FF;
        pend[0] = 1'h1;
        pend[9] = 1'h1;
        serve(9, 1'h1);
        pend[1] = 1'h1;
        quiet("high_blocked");
        do_return_from_irq_insn();
        serve(1, 1'h1);
        do_return_from_irq_insn();
        serve(0, 1'h0);
        pend[3] = 1'h1;
        quiet("low_blocked");
        pend[9] = 1'h1;
        serve(9, 1'h1);
        do_return_from_irq_insn();
        do_return_from_irq_insn();
        serve(3, 1'h0);
        do_return_from_irq_insn();
    endtask : t_levels

    task automatic t_flash;
        @(posedge i_clk);
        i_flash_busy <= 1'h1;
        pend[7] = 1'h1;
        en[7]   = 1'h1;
        quiet("flash_defer");
        chk("stall", 22'(o_cpu_stall), 22'h1);
        @(posedge i_clk);
        i_flash_busy <= 1'h0;
        serve(7, 1'h0);
        do_return_from_irq_insn();
    endtask : t_flash

    task automatic t_gate;
        @(posedge i_clk);
        i_global_enable <= 1'h0;
        t_len           <= 4'h3;
        pend[2] = 1'h1;
        en[2]   = 1'h1;
        quiet("gate_global");
        chk("seen_off", 22'(o_request_seen), 22'h0);
        en[2] = 1'h0;
        @(posedge i_clk);
        i_global_enable <= 1'h1;
        quiet("gate_enable");
        en[2] = 1'h1;
        serve(2, 1'h0);
        do_return_from_irq_insn();
    endtask : t_gate

    initial begin
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'h1;
        @(posedge i_clk);
        i_global_enable <= 1'h1;
        @(negedge i_clk);
        t_latency();
        t_order();
        t_levels();
        t_flash();
        t_gate();
        close_out();
    end
endmodule : tb
`default_nettype wire
